// ===== pkg/tx_link_pkg.sv
// Constants, field layouts and types for the transmit link control block
// How it works
// - Sync pin type, invert and obey/force control
// - Bypass sends octet with two zero MSBs
// - Symbol invert flips bits a through j
// - Checksum mode 00 sums configuration bytes
// - Checksum mode 01 sums LSB-aligned fields
// - Checksum mode 10 sends zero; 11 unused
// - Injection 1 puts pattern after encoder
// - Injection 0 at samples, 10 at scrambler
// - Select 0 normal, checkerboard, word toggle
// - PN31 and PN23 pattern generators
// - PN15, ramp, repeat and single user pattern
// - PN9 and PN7 pattern generators
// - Sync request drives code group synchronization
// - Alignment sequence starts on chosen multiframe
package tx_link_pkg;
   localparam int ADR_W = 14;
   localparam int IDX_W = 12;
   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_SYNC_CODING = 12'h572;
   localparam logic [IDX_W-1:0] IDX_CKSUM_TEST = 12'h573;
   localparam logic [IDX_W-1:0] IDX_LINK_CTRL = 12'h5F0;
   localparam logic [IDX_W-1:0] IDX_USER_LO = 12'h5F1;
   localparam logic [IDX_W-1:0] IDX_USER_HI = 12'h5F2;
   localparam logic [IDX_W-1:0] IDX_STATUS = 12'h5F3;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] SYNC_CODING_RD_MASK = 8'hF7;
   // Field positions
   localparam int SYNC_CTL_LO = 6;
   localparam int SYNC_INV_BIT = 5;
   localparam int SYNC_TYPE_BIT = 4;
   localparam int BYPASS_BIT = 2;
   localparam int SYMINV_BIT = 1;
   localparam int CS_LO = 6;
   localparam int INJ_LO = 4;
   localparam int PAT_LO = 0;
   localparam int LINK_EN_BIT = 0;
   localparam int ILAS_DLY_LO = 4;
   typedef enum logic [1:0] {
      SYNC_NORMAL = 2'b00,
      SYNC_FORCE_CGS = 2'b10,
      SYNC_FORCE_DATA = 2'b11
   } sync_ctl_t;
   typedef enum logic [1:0] {
      CS_BYTES = 2'b00,
      CS_FIELDS = 2'b01,
      CS_ZERO = 2'b10
   } cs_mode_t;
   typedef enum logic [1:0] {
      INJ_SAMPLE = 2'b00,
      INJ_PHY = 2'b01,
      INJ_SCR = 2'b10
   } inj_t;
   typedef enum logic [3:0] {
      PAT_OFF = 4'h0,
      PAT_CHECKER = 4'h1,
      PAT_TOGGLE = 4'h2,
      PAT_PN31 = 4'h3,
      PAT_PN23 = 4'h4,
      PAT_PN15 = 4'h5,
      PAT_PN9 = 4'h6,
      PAT_PN7 = 4'h7,
      PAT_RAMP = 4'h8,
      PAT_USER_REP = 4'hE,
      PAT_USER_ONE = 4'hF
   } pat_t;
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_CGS = 3'b001,
      ST_WAIT = 3'b010,
      ST_ILAS = 3'b011,
      ST_DATA = 3'b100
   } link_state_t;
   localparam logic [3:0] ILAS_MF_LAST = 4'h3;
   localparam logic [15:0] CHECKER_A = 16'hAAAA;
   localparam logic [15:0] CHECKER_B = 16'h5555;
   localparam logic [15:0] WORD_ONES = 16'hFFFF;
   localparam logic [30:0] PN_SEED = 31'h7FFFFFFF;
   // PN lengths and taps, indexed by select minus PAT_PN31
   localparam int PN_LEN[5] = '{31, 23, 15, 9, 7};
   localparam int PN_TAP[5] = '{28, 18, 14, 5, 6};
   // Link configuration table: 8 bytes, ten fields
   localparam int CFG_BYTES = 8;
   localparam int CFG_FIELDS = 10;
   localparam int FLD_LO[CFG_FIELDS] = '{0, 8, 16, 24, 31, 32, 40, 48, 56, 62};
   localparam int FLD_W[CFG_FIELDS] = '{8, 4, 5, 5, 1, 8, 5, 8, 5, 2};
endpackage

// ===== logic/tx_link_ctrl.sv
// Transmit link control: sync conditioning, coding options, checksum, test patterns
`timescale 1ns/1ps
`default_nettype none
module tx_link_ctrl (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [tx_link_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic sync_request_p_i,
   input wire logic sync_request_n_i,
   input wire logic lmfc_i,
   input wire logic [63:0] cfg_table_i,
   input wire logic [15:0] sample_i,
   input wire logic [7:0] scr_i,
   input wire logic [7:0] enc_octet_i,
   input wire logic [9:0] enc_symbol_i,
   output logic [15:0] sample_o,
   output logic [7:0] scr_o,
   output logic [9:0] symbol_o,
   output logic [7:0] checksum_o,
   output logic cgs_o,
   output logic ilas_o,
   output logic data_o
);
   import tx_link_pkg::*;

   logic [7:0] sync_coding_q;
   logic [7:0] cksum_test_q;
   logic [7:0] link_ctrl_q;
   logic [7:0] user_lo_q;
   logic [7:0] user_hi_q;
   logic ack_q;
   logic [31:0] rd_q;

   // Bus decode
   wire [IDX_W-1:0] idx = wb_adr_i[ADR_W-1:2];
   wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
   wire wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];
   wire [7:0] wr_byte = wb_dat_i[7:0];

   // Field views
   wire [1:0] sync_ctl = sync_coding_q[SYNC_CTL_LO+1:SYNC_CTL_LO];
   wire sync_inv = sync_coding_q[SYNC_INV_BIT];
   wire sync_single = sync_coding_q[SYNC_TYPE_BIT];
   wire enc_bypass = sync_coding_q[BYPASS_BIT];
   wire sym_invert = sync_coding_q[SYMINV_BIT];
   wire [1:0] cs_mode = cksum_test_q[CS_LO+1:CS_LO];
   wire [1:0] inj_pt = cksum_test_q[INJ_LO+1:INJ_LO];
   wire [3:0] pat_sel = cksum_test_q[PAT_LO+3:PAT_LO];
   wire link_en = link_ctrl_q[LINK_EN_BIT];
   wire [3:0] ilas_dly = link_ctrl_q[ILAS_DLY_LO+3:ILAS_DLY_LO];
   wire [15:0] user_word = {user_hi_q, user_lo_q};

   // Register writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_coding_q <= RST_REG;
         cksum_test_q <= RST_REG;
         link_ctrl_q <= RST_REG;
         user_lo_q <= RST_REG;
         user_hi_q <= RST_REG;
      end else if (ce_i && wr_lane0) begin
         case (idx)
            IDX_SYNC_CODING: sync_coding_q <= wr_byte;
            IDX_CKSUM_TEST: cksum_test_q <= wr_byte;
            IDX_LINK_CTRL: link_ctrl_q <= wr_byte;
            IDX_USER_LO: user_lo_q <= wr_byte;
            IDX_USER_HI: user_hi_q <= wr_byte;
            default: ;
         endcase
      end
   end

   // Sync request conditioning
   // Differential reads high only when p is above n
   wire pin_raw = sync_single ? sync_request_p_i
                              : (sync_request_p_i & ~sync_request_n_i);
   wire pin_level = pin_raw ^ sync_inv;
   logic [2:0] sync_ff_q;
   logic sync_lvl_q;

   // A change counts once the last two stages agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_ff_q <= 3'h7;
         sync_lvl_q <= 1'b1;
      end else if (ce_i) begin
         sync_ff_q <= {sync_ff_q[1:0], pin_level};
         if (sync_ff_q[2] == sync_ff_q[1]) begin
            sync_lvl_q <= sync_ff_q[2];
         end
      end
   end

   // Pin is active low: low level requests synchronization
   // Code 01 is unused and behaves as normal mode
   wire sync_req = (sync_ctl == SYNC_FORCE_CGS) |
                   ((sync_ctl != SYNC_FORCE_DATA) & ~sync_lvl_q);

   // Link sequencing
   link_state_t state_q, state_d;
   logic [3:0] mf_cnt_q, mf_cnt_d;

   always_comb begin
      state_d = state_q;
      mf_cnt_d = mf_cnt_q;
      case (state_q)
         ST_OFF: begin
            if (link_en) begin
               state_d = ST_CGS;
            end
         end
         ST_CGS: begin
            mf_cnt_d = 4'h0;
            if (!sync_req) begin
               state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (sync_req) begin
               state_d = ST_CGS;
            end else if (lmfc_i) begin
               if (mf_cnt_q == ilas_dly) begin
                  state_d = ST_ILAS;
                  mf_cnt_d = 4'h0;
               end else begin
                  mf_cnt_d = mf_cnt_q + 4'h1;
               end
            end
         end
         ST_ILAS: begin
            if (sync_req) begin
               state_d = ST_CGS;
            end else if (lmfc_i) begin
               if (mf_cnt_q == ILAS_MF_LAST) begin
                  state_d = ST_DATA;
               end else begin
                  mf_cnt_d = mf_cnt_q + 4'h1;
               end
            end
         end
         ST_DATA: begin
            if (sync_req) begin
               state_d = ST_CGS;
            end
         end
         default: state_d = ST_OFF;
      endcase
      if (!link_en) begin
         state_d = ST_OFF;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_OFF;
         mf_cnt_q <= 4'h0;
         cgs_o <= 1'b0;
         ilas_o <= 1'b0;
         data_o <= 1'b0;
      end else if (ce_i) begin
         state_q <= state_d;
         mf_cnt_q <= mf_cnt_d;
         cgs_o <= (state_d == ST_CGS) | (state_d == ST_WAIT);
         ilas_o <= (state_d == ST_ILAS);
         data_o <= (state_d == ST_DATA);
      end
   end

   // Checksum over the link configuration table
   function automatic logic [7:0] sum_bytes(input logic [63:0] t);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < CFG_BYTES; i++) begin
         s = s + t[i*8 +: 8];
      end
      return s;
   endfunction

   function automatic logic [7:0] sum_fields(input logic [63:0] t);
      logic [7:0] s;
      logic [63:0] f;
      s = 8'h00;
      for (int i = 0; i < CFG_FIELDS; i++) begin
         f = (t >> FLD_LO[i]) & ((64'h1 << FLD_W[i]) - 64'h1);
         s = s + f[7:0];
      end
      return s;
   endfunction

   wire [7:0] cs_bytes = sum_bytes(cfg_table_i);
   wire [7:0] cs_fields = sum_fields(cfg_table_i);
   // Unused mode 11 falls back to the byte sum
   wire [7:0] cs_d = (cs_mode == CS_FIELDS) ? cs_fields :
                     (cs_mode == CS_ZERO) ? 8'h00 : cs_bytes;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         checksum_o <= 8'h00;
      end else if (ce_i) begin
         checksum_o <= cs_d;
      end
   end

   // Test pattern generator
   function automatic logic [30:0] pn_next(input logic [30:0] s, input int k);
      logic fb;
      logic [30:0] mask;
      fb = s[PN_LEN[k]-1] ^ s[PN_TAP[k]-1];
      mask = 31'((64'h1 << PN_LEN[k]) - 64'h1);
      return {s[29:0], fb} & mask;
   endfunction

   logic [15:0] word_q;
   logic [30:0] pn_q;
   logic [3:0] sel_prev_q;
   logic user_sent_q;
   logic [15:0] word_d;
   logic [30:0] pn_d;
   logic test_on;
   wire sel_change = (pat_sel != sel_prev_q);
   wire [2:0] pn_k = 3'(pat_sel - PAT_PN31);

   always_comb begin
      word_d = 16'h0000;
      pn_d = pn_q;
      test_on = 1'b1;
      case (pat_sel)
         PAT_CHECKER: word_d = (word_q == CHECKER_A) ? CHECKER_B : CHECKER_A;
         PAT_TOGGLE: word_d = (word_q == WORD_ONES) ? 16'h0000 : WORD_ONES;
         PAT_PN31, PAT_PN23: begin
            pn_d = pn_next(pn_q, int'(pn_k));
            word_d = pn_d[15:0];
         end
         PAT_PN15: begin
            pn_d = pn_next(pn_q, int'(pn_k));
            word_d = pn_d[15:0];
         end
         PAT_PN9, PAT_PN7: begin
            pn_d = pn_next(pn_q, int'(pn_k));
            word_d = pn_d[15:0];
         end
         PAT_RAMP: word_d = word_q + 16'h0001;
         PAT_USER_REP: word_d = user_word;
         PAT_USER_ONE: word_d = user_sent_q ? 16'h0000 : user_word;
         default: test_on = 1'b0;
      endcase
      if (sel_change) begin
         pn_d = PN_SEED;
         word_d = 16'h0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         word_q <= 16'h0000;
         pn_q <= PN_SEED;
         sel_prev_q <= PAT_OFF;
         user_sent_q <= 1'b0;
      end else if (ce_i) begin
         word_q <= word_d;
         pn_q <= pn_d;
         sel_prev_q <= pat_sel;
         user_sent_q <= !sel_change && (pat_sel == PAT_USER_ONE);
      end
   end

   // Injection and symbol coding; unused point 11 injects nowhere
   wire inj_sample = test_on & (inj_pt == INJ_SAMPLE);
   wire inj_scr = test_on & (inj_pt == INJ_SCR);
   wire inj_phy = test_on & (inj_pt == INJ_PHY);
   wire [9:0] sym_coded = enc_bypass ? {2'b00, enc_octet_i} : enc_symbol_i;
   wire [9:0] sym_sel = inj_phy ? word_q[9:0] : sym_coded;
   wire [9:0] sym_out = sym_sel ^ {10{sym_invert}};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sample_o <= 16'h0000;
         scr_o <= 8'h00;
         symbol_o <= 10'h000;
      end else if (ce_i) begin
         sample_o <= inj_sample ? word_q : sample_i;
         scr_o <= inj_scr ? word_q[7:0] : scr_i;
         symbol_o <= sym_out;
      end
   end

   // Read mux; unmapped reads return zero
   wire [7:0] status = {3'b000, ~sync_lvl_q, sync_req, state_q};
   wire [7:0] rd_byte = (idx == IDX_SYNC_CODING) ? (sync_coding_q & SYNC_CODING_RD_MASK) :
                        (idx == IDX_CKSUM_TEST) ? cksum_test_q :
                        (idx == IDX_LINK_CTRL) ? link_ctrl_q :
                        (idx == IDX_USER_LO) ? user_lo_q :
                        (idx == IDX_USER_HI) ? user_hi_q :
                        (idx == IDX_STATUS) ? status : 8'h00;

   // One wait state; ack drops the cycle after it was given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rd_q <= 32'h00000000;
      end else if (ce_i) begin
         ack_q <= bus_req;
         if (bus_req) begin
            rd_q <= {24'h000000, rd_byte};
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rd_q;
endmodule
`default_nettype wire

// ===== verif/tx_link_ctrl_props.sv
// Concurrent property checker for the transmit link control block
`timescale 1ns/1ps
`default_nettype none
module tx_link_ctrl_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [tx_link_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic lmfc_i,
   input wire logic cgs_o,
   input wire logic ilas_o,
   input wire logic data_o
);
   import tx_link_pkg::*;
   wire logic [IDX_W-1:0] adr_idx = wb_adr_i[ADR_W-1:2];
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_taken; wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o; endproperty
   property p_ack_pulse; wb_ack_o && ce_i |=> !wb_ack_o; endproperty
   property p_dat_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
   property p_rsvd_bit; wb_ack_o && !wb_we_i && adr_idx == IDX_SYNC_CODING |-> !wb_dat_o[3]; endproperty
   property p_states; $onehot0({cgs_o, ilas_o, data_o}); endproperty
   property p_ilas_lmfc; $rose(ilas_o) |-> $past(lmfc_i); endproperty
   property p_ilas_wait; $rose(ilas_o) |-> $past(cgs_o); endproperty
   property p_data_ilas; $rose(data_o) |-> $past(ilas_o) && $past(lmfc_i); endproperty
   property p_data_back; $fell(data_o) |-> !ilas_o; endproperty
   a_ack_taken: assert property (p_ack_taken) else $error("request not acked next cycle");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_dat_upper: assert property (p_dat_upper) else $error("read data upper bits set");
   a_rsvd_bit: assert property (p_rsvd_bit) else $error("reserved bit reads one");
   a_states: assert property (p_states) else $error("link phases overlap");
   a_ilas_lmfc: assert property (p_ilas_lmfc) else $error("alignment off boundary");
   a_ilas_wait: assert property (p_ilas_wait) else $error("alignment without sync phase");
   a_data_ilas: assert property (p_data_ilas) else $error("data without alignment");
   a_data_back: assert property (p_data_back) else $error("data fell back to alignment");
   c_ack: cover property (wb_ack_o && wb_we_i);
   c_ilas: cover property ($rose(ilas_o));
   c_data: cover property ($rose(data_o));
endmodule
bind tx_link_ctrl tx_link_ctrl_props i_props (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_dat_o, .wb_ack_o, .lmfc_i, .cgs_o, .ilas_o, .data_o);
`default_nettype wire

// ===== verif/sync_partner.sv
// Link receiver model: sync request pin pair and multiframe pulses
`timescale 1ns/1ps
`default_nettype none
module sync_partner (
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic se_i,
   output logic p_o,
   output logic n_o,
   output logic lmfc_o
);
   logic [2:0] cnt_q = 3'h0;
   logic p_q = 1'b1;
   logic n_q = 1'b0;
   logic l_q = 1'b0;
   always @(posedge clk_i) begin
      cnt_q <= cnt_q + 3'h1;
      l_q <= cnt_q == 3'h7;
      p_q <= !req_i; // Request is active low
      // Unused leg in single-ended mode wanders
      n_q <= se_i ? !n_q : req_i;
   end
   assign p_o = p_q;
   assign n_o = n_q;
   assign lmfc_o = l_q;
endmodule
`default_nettype wire

// ===== verif/tx_link_ctrl_tb.sv
// Self-checking bench for the transmit link control block
`timescale 1ns/1ps
`default_nettype none
module tx_link_ctrl_tb;
   import tx_link_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, req = 1'b1, se = 1'b0, ce = 1'b1;
   logic [ADR_W-1:0] wb_adr_i = '0;
   logic [31:0] wb_dat_i = '0, wb_dat_o, rq;
   logic [63:0] cfg_table_i = 64'hFEDCBA9876543210;
   logic [63:0] h;
   logic [15:0] sample_i = 16'h3C5A, sample_o, a, w0, w1, ex;
   logic [7:0] scr_i = 8'h96, enc_octet_i = 8'hA5, scr_o, checksum_o, b, bs, fs;
   logic [9:0] enc_symbol_i = 10'h2C3, symbol_o, c;
   logic wb_ack_o, sync_request_p_i, sync_request_n_i, lmfc_i, cgs_o, ilas_o, data_o;
   int num_errors = 0, n_tests = 0, ln, tp;
   tx_link_ctrl i_dut (.clk_i, .rst_i, .ce_i(ce), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .sync_request_p_i, .sync_request_n_i, .lmfc_i,
      .cfg_table_i, .sample_i, .scr_i, .enc_octet_i, .enc_symbol_i, .sample_o, .scr_o, .symbol_o,
      .checksum_o, .cgs_o, .ilas_o, .data_o);
   sync_partner i_far (.clk_i, .req_i(req), .se_i(se), .p_o(sync_request_p_i), .n_o(sync_request_n_i),
      .lmfc_o(lmfc_i));
   initial forever #20 clk_i = ~clk_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {24'h0, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rq = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
      repeat (4) @(posedge clk_i);
   endtask
   task automatic rd(input logic [11:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rq, {24'h0, exp});
   endtask
   // Bounded wait for a phase level, then record it
   task automatic hi(ref logic s);
      for (int i = 0; i < 300 && s !== 1'b1; i++) @(posedge clk_i);
      chk(s, 1'b1);
   endtask
   task automatic complete_run;
      if (num_errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(IDX_SYNC_CODING, 8'h00);
      rd(IDX_CKSUM_TEST, 8'h00);
      wr(IDX_SYNC_CODING, 8'hFF);
      rd(IDX_SYNC_CODING, 8'hF7);
      wr(12'h000, 8'h5A);
      rd(12'h000, 8'h00);
      for (int m = 0; m < 4; m++) begin
         wr(IDX_SYNC_CODING, {5'h0, m[1:0], 1'b0});
         c = m[1] ? {2'b00, enc_octet_i} : enc_symbol_i;
         if (m[0]) c = ~c;
         chk(symbol_o, c);
      end
      wr(IDX_SYNC_CODING, 8'h00);
      bs = 8'h0;
      fs = 8'h0;
      for (int f = 0; f < CFG_FIELDS; f++) fs += 8'((cfg_table_i >> FLD_LO[f]) & ((64'h1 << FLD_W[f]) - 1));
      for (int k = 0; k < CFG_BYTES; k++) bs += cfg_table_i[8*k +: 8];
      for (int m = 0; m < 4; m++) begin
         wr(IDX_CKSUM_TEST, {m[1:0], 6'h0});
         chk(checksum_o, m == 1 ? fs : (m == 2 ? 8'h0 : bs));
      end
      for (int s = 1; s < 9; s++) begin
         wr(IDX_CKSUM_TEST, 8'(s));
         // Bit 0 history: each PN sequence obeys b[t] = b[t-len] ^ b[t-tap]
         for (int t = 0; t < 40; t++) begin
            if (t > 0) @(posedge clk_i);
            w0 = w1;
            w1 = sample_o;
            h = {h[62:0], w1[0]};
         end
         ex = s < 3 ? ~w0 : (s == 8 ? w0 + 16'h1 : {w0[14:0], 1'b0});
         if (s > 2 && s < 8) begin
            ln = PN_LEN[s-3];
            tp = PN_TAP[s-3];
            ex[0] = h[ln] ^ h[tp];
            if (ln < 16) ex = ex & 16'((32'h1 << ln) - 1);
         end
         chk(w1, ex);
         if (s == 1) chk(w0 == CHECKER_A || w0 == CHECKER_B, 1);
         if (s == 2) chk(w0 == WORD_ONES || w0 == 16'h0, 1);
      end
      // Clock enable low freezes the running ramp
      ce <= 1'b0;
      @(posedge clk_i);
      a = sample_o;
      repeat (3) @(posedge clk_i);
      chk(sample_o, a);
      ce <= 1'b1;
      @(posedge clk_i);
      // Code 3 is unused and must leave every path untouched
      for (int j = 0; j < 4; j++) begin
         wr(IDX_CKSUM_TEST, {2'h0, j[1:0], 4'h8});
         a = sample_o;
         b = scr_o;
         c = symbol_o;
         @(posedge clk_i);
         chk(sample_o, j == 0 ? 16'(a + 16'h1) : sample_i);
         chk(scr_o, j == 2 ? 8'(b + 8'h1) : scr_i);
         chk(symbol_o, j == 1 ? 10'(c + 10'h1) : enc_symbol_i);
      end
      wr(IDX_CKSUM_TEST, 8'h00);
      chk(sample_o, sample_i);
      wr(IDX_USER_LO, 8'h34);
      wr(IDX_USER_HI, 8'h12);
      wr(IDX_CKSUM_TEST, 8'h0E);
      chk(sample_o, 16'h1234);
      wr(IDX_CKSUM_TEST, 8'h00);
      // Single user word stands for one cycle only
      bus(1'b1, IDX_CKSUM_TEST, 8'h0F);
      tp = 0;
      repeat (8) begin
         tp += int'(sample_o == 16'h1234);
         @(posedge clk_i);
      end
      chk(tp, 1);
      chk(sample_o, 16'h0);
      wr(IDX_LINK_CTRL, 8'h01);
      hi(cgs_o);
      req <= 1'b0;
      hi(ilas_o);
      hi(data_o);
      req <= 1'b1;
      hi(cgs_o);
      wr(IDX_SYNC_CODING, 8'hC0);
      hi(data_o);
      req <= 1'b0;
      wr(IDX_SYNC_CODING, 8'h80);
      hi(cgs_o);
      wr(IDX_SYNC_CODING, 8'h00);
      hi(data_o);
      wr(IDX_SYNC_CODING, 8'h20);
      hi(cgs_o);
      se <= 1'b1;
      wr(IDX_SYNC_CODING, 8'h10);
      hi(data_o);
      req <= 1'b1;
      hi(cgs_o);
      // Forced data out of the sync phase; alignment on the third boundary
      wr(IDX_LINK_CTRL, 8'h21);
      bus(1'b1, IDX_SYNC_CODING, 8'hC0);
      tp = 0;
      for (int i = 0; i < 300 && ilas_o !== 1'b1; i++) begin
         tp += int'(lmfc_i);
         @(posedge clk_i);
      end
      chk(tp, 3);
      complete_run;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      complete_run;
   end
endmodule
`default_nettype wire
